// ### rtl/backplane_irq_line_allocator.v
// allocator of the four shared backplane interrupt lines among
// processor modules, evaluated on each run request strobe
// assumes request inputs are stable and synchronous to clk
// assumes slot 0 is the leftmost slot of the rack
`timescale 1ns/1ps
`default_nettype none
`include "irq_alloc_defines.vh"

// Summary of operation
// - four lines only, never more granted
// - event line: up to four, one processor
// - exclusive task line serves that task alone
// - per processor: one event, one exclusive line
// - one to four events take one line
// - network line allocated via leftmost processor
// - all network modules share one line
// - network line may join leftmost event line
// - network line never joins exclusive line
// - unmet requests give code 44, no run
module backplane_irq_line_allocator
(
  input  wire                              clk,
  input  wire                              rst_n,
  input  wire                              run_req,
  input  wire [`NUM_PROC-1:0]              proc_present,
  input  wire [`NUM_PROC*`EV_CNT_W-1:0]    event_count,
  input  wire [`NUM_PROC-1:0]              exclusive_control_task,
  input  wire                              net_present,
  output reg  [`NUM_PROC-1:0]              event_grant_reg,
  output reg  [`NUM_PROC*`LINE_W-1:0]      event_line_reg,
  output reg  [`NUM_PROC-1:0]              excl_grant_reg,
  output reg  [`NUM_PROC*`LINE_W-1:0]      excl_line_reg,
  output reg                               net_grant_reg,
  output reg  [`LINE_W-1:0]                net_line_reg,
  output reg                               net_shared_reg,
  output reg                               alloc_valid_reg,
  output reg                               run_enable_reg,
  output reg                               fail_reg,
  output reg  [7:0]                        fail_code_reg
);

  // ----------------------------------------------------------------
  // per-slot demand and running line count
  // ----------------------------------------------------------------
  wire [`LINE_CNT_W-1:0]         base      [0:`NUM_PROC];
  wire [`LINE_CNT_W-1:0]         excl_cnt  [0:`NUM_PROC];
  wire [`NUM_PROC-1:0]           ev_need;
  wire [`NUM_PROC-1:0]           ex_need;
  wire [`NUM_PROC-1:0]           ev_over;
  wire [`NUM_PROC*`LINE_W-1:0]   ev_line;
  wire [`NUM_PROC*`LINE_W-1:0]   ex_line;

  assign base[0]     = {`LINE_CNT_W{1'b0}};
  assign excl_cnt[0] = {`LINE_CNT_W{1'b0}};

  // ----------------------------------------------------------------
  // line ids handed out in slot order, events before exclusive
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `NUM_PROC; i = i + 1)
    begin : g_slot
      wire [`EV_CNT_W-1:0]   cnt;
      wire [`LINE_CNT_W-1:0] ex_base;
      assign cnt = event_count[i*`EV_CNT_W +: `EV_CNT_W];
      // any count from one to four needs the same single line
      assign ev_need[i] = proc_present[i] &
                          (cnt != {`EV_CNT_W{1'b0}});
      // more than four events cannot fit on the one event line
      assign ev_over[i] = proc_present[i] &
                          (cnt > `MAX_EV_PER_LN);
      assign ex_need[i] = proc_present[i] & exclusive_control_task[i];
      // exclusive task always takes a fresh line of its own
      assign ex_base = base[i] + {{(`LINE_CNT_W-1){1'b0}},
                                  ev_need[i]};
      assign base[i+1] = ex_base +
                         {{(`LINE_CNT_W-1){1'b0}}, ex_need[i]};
      assign excl_cnt[i+1] = excl_cnt[i] +
                             {{(`LINE_CNT_W-1){1'b0}}, ex_need[i]};
      // line ids read as zero where the slot holds no grant
      assign ev_line[i*`LINE_W +: `LINE_W] =
        base[i][`LINE_W-1:0] & {`LINE_W{ev_need[i]}};
      assign ex_line[i*`LINE_W +: `LINE_W] =
        ex_base[`LINE_W-1:0] & {`LINE_W{ex_need[i]}};
    end
  endgenerate

  // ----------------------------------------------------------------
  // network modules line through the leftmost processor
  // ----------------------------------------------------------------
  wire [`PROC_IDX_W-1:0] lm_idx;
  wire                   lm_any;

  leftmost_finder u_leftmost
  (
    .present (proc_present),
    .idx     (lm_idx),
    .any     (lm_any)
  );

  wire                   net_need;
  wire                   lm_has_ev;
  wire                   net_extra;
  wire [`LINE_CNT_W-1:0] total_lines;
  wire [`LINE_W-1:0]     net_line;
  wire [`LINE_W-1:0]     lm_ev_line;

  // however many network modules, one request in total
  assign net_need  = net_present & lm_any;
  assign lm_has_ev = ev_need[lm_idx];
  // share the leftmost event line, otherwise take a fresh line
  assign net_extra = net_need & ~lm_has_ev;
  assign total_lines = base[`NUM_PROC] +
                       {{(`LINE_CNT_W-1){1'b0}}, net_extra};
  // a fresh line is past every exclusive line, so never shared
  assign lm_ev_line = ev_line[lm_idx*`LINE_W +: `LINE_W];
  assign net_line = lm_has_ev ?
                    lm_ev_line :
                    base[`NUM_PROC][`LINE_W-1:0];

  // ----------------------------------------------------------------
  // failure decision
  // ----------------------------------------------------------------
  wire fail_ev;
  wire fail_excl;
  wire fail_lines;
  wire fail_orphan;
  wire fail_now;

  // a group of more than four events fits no line
  assign fail_ev     = |ev_over;
  // exclusive task limit of the rack enforced here too
  assign fail_excl   = excl_cnt[`NUM_PROC] > `MAX_EXCL_RACK;
  // demand beyond the four backplane lines
  assign fail_lines  = total_lines > `NUM_LINES;
  // network modules need a processor to claim through
  assign fail_orphan = net_present & ~lm_any;
  assign fail_now    = fail_ev | fail_excl | fail_lines |
                       fail_orphan;

  // ----------------------------------------------------------------
  // next result, a full refusal whenever any demand cannot be met
  // ----------------------------------------------------------------
  reg [`NUM_PROC-1:0]         event_grant_next;
  reg [`NUM_PROC*`LINE_W-1:0] event_line_next;
  reg [`NUM_PROC-1:0]         excl_grant_next;
  reg [`NUM_PROC*`LINE_W-1:0] excl_line_next;
  reg                         net_grant_next;
  reg [`LINE_W-1:0]           net_line_next;
  reg                         net_shared_next;
  reg                         run_enable_next;
  reg                         fail_next;
  reg [7:0]                   fail_code_next;

  always @*
  begin
    if (fail_now)
    begin
      // refuse everything so no task enters run
      event_grant_next = {`NUM_PROC{1'b0}};
      event_line_next  = {`NUM_PROC*`LINE_W{1'b0}};
      excl_grant_next  = {`NUM_PROC{1'b0}};
      excl_line_next   = {`NUM_PROC*`LINE_W{1'b0}};
      net_grant_next   = 1'b0;
      net_line_next    = `LINE_RST;
      net_shared_next  = 1'b0;
      run_enable_next  = 1'b0;
      fail_next        = 1'b1;
      fail_code_next   = `FAIL_CODE;
    end
    else
    begin
      event_grant_next = ev_need;
      event_line_next  = ev_line;
      excl_grant_next  = ex_need;
      excl_line_next   = ex_line;
      net_grant_next   = net_need;
      net_line_next    = net_need ? net_line : `LINE_RST;
      net_shared_next  = net_need & lm_has_ev;
      run_enable_next  = 1'b1;
      fail_next        = 1'b0;
      fail_code_next   = `CODE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // result registers, loaded on the strobe and held until the next
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      event_grant_reg <= {`NUM_PROC{1'b0}};
      event_line_reg  <= {`NUM_PROC*`LINE_W{1'b0}};
      excl_grant_reg  <= {`NUM_PROC{1'b0}};
      excl_line_reg   <= {`NUM_PROC*`LINE_W{1'b0}};
      net_grant_reg   <= 1'b0;
      net_line_reg    <= `LINE_RST;
      net_shared_reg  <= 1'b0;
      alloc_valid_reg <= 1'b0;
      run_enable_reg  <= 1'b0;
      fail_reg        <= 1'b0;
      fail_code_reg   <= `CODE_NONE;
    end
    else if (run_req)
    begin
      event_grant_reg <= event_grant_next;
      event_line_reg  <= event_line_next;
      excl_grant_reg  <= excl_grant_next;
      excl_line_reg   <= excl_line_next;
      net_grant_reg   <= net_grant_next;
      net_line_reg    <= net_line_next;
      net_shared_reg  <= net_shared_next;
      alloc_valid_reg <= 1'b1;
      run_enable_reg  <= run_enable_next;
      fail_reg        <= fail_next;
      fail_code_reg   <= fail_code_next;
    end
  end

endmodule // backplane_irq_line_allocator
`default_nettype wire

// ### rtl/irq_alloc_defines.vh
// constants for the backplane interrupt line allocator
// assumes a single clock and an active-low asynchronous reset
`ifndef IRQ_ALLOC_DEFINES_VH
`define IRQ_ALLOC_DEFINES_VH

// ----------------------------------------------------------------
// rack shape
// ----------------------------------------------------------------
`define NUM_PROC      4
`define PROC_IDX_W    2
`define LINE_W        2
`define EV_CNT_W      3
`define LINE_CNT_W    4

// ----------------------------------------------------------------
// limits
// ----------------------------------------------------------------
`define NUM_LINES     4'h4
`define MAX_EV_PER_LN 3'h4
`define MAX_EXCL_RACK 4'h2

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define FAIL_CODE     8'h2C
`define CODE_NONE     8'h00
`define LINE_RST      2'h0

`endif

// ### rtl/leftmost_finder.v
// priority encoder giving the lowest-numbered present processor slot
// assumes slot 0 is the leftmost slot in the rack
`timescale 1ns/1ps
`default_nettype none
`include "irq_alloc_defines.vh"

module leftmost_finder
(
  input  wire [`NUM_PROC-1:0]   present,
  output reg  [`PROC_IDX_W-1:0] idx,
  output reg                    any
);

  integer k;

  // ----------------------------------------------------------------
  // scan from the right so the leftmost hit wins
  // ----------------------------------------------------------------
  always @*
  begin
    idx = {`PROC_IDX_W{1'b0}};
    any = 1'b0;
    for (k = `NUM_PROC - 1; k >= 0; k = k - 1)
    begin
      if (present[k])
      begin
        idx = k[`PROC_IDX_W-1:0];
        any = 1'b1;
      end
    end
  end

endmodule // leftmost_finder
`default_nettype wire

// ### sim/irq_alloc_properties.sv
// port assertions for the interrupt line allocator
// assumes the allocator header is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "irq_alloc_defines.vh"
module irq_alloc_properties
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        run_req,
  input wire logic [3:0]  proc_present,
  input wire logic [11:0] event_count,
  input wire logic        net_present,
  input wire logic [3:0]  event_grant_reg,
  input wire logic [3:0]  excl_grant_reg,
  input wire logic        net_grant_reg,
  input wire logic        net_shared_reg,
  input wire logic        alloc_valid_reg,
  input wire logic        run_enable_reg,
  input wire logic        fail_reg,
  input wire logic [7:0]  fail_code_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_fail_code: assert property
    (fail_reg |-> fail_code_reg == `FAIL_CODE) else $error("bad code");
  a_fail_norun: assert property
    (fail_reg |-> !run_enable_reg && !net_grant_reg
     && {event_grant_reg, excl_grant_reg} == 8'h00) else $error("run");
  a_line_total: assert property
    ($countones(event_grant_reg) + $countones(excl_grant_reg)
     + (net_grant_reg && !net_shared_reg) <= 4) else $error("lines");
  a_excl_max: assert property
    ($countones(excl_grant_reg) <= 2) else $error("exclusive count");
  a_ev_over: assert property
    (run_req && proc_present[0] && event_count[2:0] > 3'h4 |=> fail_reg)
    else $error("events over");
  a_net_alone: assert property
    (run_req && net_present && proc_present == 4'h0 |=> fail_reg)
    else $error("net alone");
  a_answer_valid: assert property
    (run_req |=> alloc_valid_reg && run_enable_reg != fail_reg)
    else $error("no answer");
  a_hold_out: assert property
    (!run_req |=> $stable(event_grant_reg) && $stable(fail_reg))
    else $error("not held");
  a_net_shared: assert property
    (net_shared_reg |-> net_grant_reg) else $error("share");
  c_share: cover property (run_req ##1 net_shared_reg);
  c_fail: cover property (run_req ##1 fail_reg);
  c_excl2: cover property ($countones(excl_grant_reg) == 2);
endmodule // irq_alloc_properties
bind backplane_irq_line_allocator irq_alloc_properties chk_u
  (.clk(clk), .rst_n(rst_n), .run_req(run_req),
   .proc_present(proc_present), .event_count(event_count),
   .net_present(net_present), .event_grant_reg(event_grant_reg),
   .excl_grant_reg(excl_grant_reg), .net_grant_reg(net_grant_reg),
   .net_shared_reg(net_shared_reg), .alloc_valid_reg(alloc_valid_reg),
   .run_enable_reg(run_enable_reg), .fail_reg(fail_reg),
   .fail_code_reg(fail_code_reg));
`default_nettype wire

// ### sim/rack_req_model.sv
// processor modules raising run requests
// assumes the bench calls request between clock edges
`timescale 1ns/1ps
`default_nettype none
module rack_req_model
(
  input  wire logic        clk,
  output var  logic        run_req,
  output var  logic [3:0]  proc_present,
  output var  logic [11:0] event_count,
  output var  logic [3:0]  exclusive_control_task,
  output var  logic        net_present
);
  initial
  begin
    run_req = 1'b0;
    {proc_present, event_count, exclusive_control_task} = 20'h0_0000;
    net_present = 1'b0;
  end
  // one-cycle strobe, fields held until next request
  task request(input logic [3:0] pp, input logic [11:0] ec,
               input logic [3:0] xt, input logic np);
  begin
    @(posedge clk);
    #1;
    {proc_present, event_count} = {pp, ec};
    exclusive_control_task = xt;
    net_present = np;
    run_req = 1'b1;
    @(posedge clk);
    #1;
    run_req = 1'b0;
  end
  endtask
endmodule // rack_req_model
`default_nettype wire

// ### sim/backplane_irq_line_allocator_tb_top.sv
// self-checking bench for the interrupt line allocator
// assumes the rack model drives every request input
`timescale 1ns/1ps
`default_nettype none
module backplane_irq_line_allocator_tb_top;
  logic       clk, rst_n, run_req, net_present, net_grant_reg;
  logic       net_shared_reg, alloc_valid_reg, run_enable_reg, fail_reg;
  logic [3:0] proc_present, exclusive_control_task;
  logic [3:0] event_grant_reg, excl_grant_reg;
  logic [11:0] event_count;
  logic [7:0] event_line_reg, excl_line_reg, fail_code_reg;
  logic [1:0] net_line_reg;
  int         err_total = 0;
  int         cmp_count = 0;
  rack_req_model rack_u (.clk(clk), .run_req(run_req),
    .proc_present(proc_present), .event_count(event_count),
    .exclusive_control_task(exclusive_control_task),
    .net_present(net_present));
  backplane_irq_line_allocator dut_u (.clk(clk), .rst_n(rst_n),
    .run_req(run_req), .proc_present(proc_present),
    .event_count(event_count), .net_present(net_present),
    .exclusive_control_task(exclusive_control_task),
    .event_grant_reg(event_grant_reg), .event_line_reg(event_line_reg),
    .excl_grant_reg(excl_grant_reg), .excl_line_reg(excl_line_reg),
    .net_grant_reg(net_grant_reg), .net_line_reg(net_line_reg),
    .net_shared_reg(net_shared_reg), .alloc_valid_reg(alloc_valid_reg),
    .run_enable_reg(run_enable_reg), .fail_reg(fail_reg),
    .fail_code_reg(fail_code_reg));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  task chk_refused;
  begin
    chk(fail_code_reg, 8'h2C);
    chk({event_grant_reg, excl_grant_reg}, 8'h00);
    chk({5'h00, net_grant_reg, run_enable_reg, fail_reg}, 8'h01);
  end
  endtask
  task stop_test;
  begin
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task s_share_four;
  begin
    rack_u.request(4'h7, 12'h084, 4'h0, 1'b1);
    chk({event_grant_reg, excl_grant_reg}, 8'h50);
    chk(event_line_reg, 8'h10);
    chk({6'h00, net_grant_reg, net_shared_reg}, 8'h03);
    chk({7'h00, run_enable_reg}, 8'h01);
    chk({6'h00, net_line_reg}, 8'h00);
  end
  endtask
  task s_four_lines;
  begin
    rack_u.request(4'h7, 12'h090, 4'h3, 1'b0);
    chk({event_grant_reg, excl_grant_reg}, 8'h63);
    chk(event_line_reg, 8'h34);
    chk({4'h0, excl_line_reg[3:0]}, 8'h08);
    rack_u.request(4'h7, 12'h090, 4'h3, 1'b1);
    chk_refused();
    rack_u.request(4'h7, 12'h060, 4'h5, 1'b1);
    chk_refused();
  end
  endtask
  task s_limits;
  begin
    rack_u.request(4'h1, 12'h005, 4'h0, 1'b0);
    chk_refused();
    rack_u.request(4'h1, 12'h004, 4'h0, 1'b0);
    chk({event_grant_reg, excl_grant_reg}, 8'h10);
    rack_u.request(4'h7, 12'h000, 4'h7, 1'b0);
    chk_refused();
    rack_u.request(4'h0, 12'h000, 4'h0, 1'b1);
    chk_refused();
  end
  endtask
  task s_leftmost;
  begin
    rack_u.request(4'h6, 12'h008, 4'h4, 1'b1);
    chk({event_grant_reg, excl_grant_reg}, 8'h24);
    chk({excl_line_reg[5:4], net_line_reg, 2'h0, net_shared_reg,
         net_grant_reg}, 8'h43);
    repeat (5) @(posedge clk);
    #1;
    chk({event_grant_reg, excl_grant_reg}, 8'h24);
  end
  endtask
  task s_reset;
  begin
    chk({alloc_valid_reg, run_enable_reg, fail_reg, 5'h00}, 8'hC0);
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({alloc_valid_reg, run_enable_reg, fail_reg, 5'h00}, 8'h00);
    chk({event_grant_reg, excl_grant_reg}, 8'h00);
    rst_n = 1'b1;
    rack_u.request(4'h1, 12'h001, 4'h0, 1'b0);
    chk({event_grant_reg, excl_grant_reg}, 8'h10);
    chk({alloc_valid_reg, run_enable_reg, fail_reg, 5'h00}, 8'hC0);
  end
  endtask
  initial
  begin
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    s_share_four();
    s_four_lines();
    s_limits();
    s_leftmost();
    s_reset();
    stop_test();
  end
  initial
  begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule // backplane_irq_line_allocator_tb_top
`default_nettype wire
